//--- hdl/rnd_defs.svh
// Constants of the return, no-op and option-load decoder.
// Assumes 14-bit instruction words and four-phase instruction cycles.
`ifndef RND_DEFS_SVH
`define RND_DEFS_SVH

// =============================================================
// Opcode patterns
`define RND_NOP_MASK 14'h3f9f
`define RND_NOP_VAL 14'h0000
`define RND_RETFI_VAL 14'h0009
`define RND_OPTLD_VAL 14'h0062
`define RND_RETLIT_MASK 14'h3c00
`define RND_RETLIT_VAL 14'h3400
// =============================================================
// Field positions, reset values and phase numbers
`define RND_GIE_BIT 7
`define RND_ZERO8 8'h00
`define RND_ZERO_PC 13'h0000
`define RND_PHASE_LAST 2'h3
`define RND_PHASE_GIE 2'h2

`endif

//--- hdl/rnd_pkg.sv
// Types of the decoder state machine; the phase sequencer does not use them.
// Assumes the defines header is included by the user files.
package rnd_pkg;
	typedef enum logic [1:0] {
		RND_EXEC = 2'h0,
		RND_IDLE = 2'h1
	} rnd_state_t;
endpackage

//--- hdl/rnd_phase_if.sv
// Interface carrying the Q-phase timing between the decoder modules.
// Assumes one core clock.
`timescale 1ns/100ps
`default_nettype none
interface rnd_phase_if;
	logic [1:0] phase;
	logic last;
	logic first;
	modport gen (output phase, output last, output first);
	modport use_ (input phase, input last, input first);
endinterface
`default_nettype wire

//--- hdl/rnd_phase_gen.sv
// Four-phase instruction cycle sequencer.
// Assumes each core clock is one phase.
`timescale 1ns/100ps
`default_nettype none
`include "rnd_defs.svh"
module rnd_phase_gen (
	input wire logic i_clk,
	input wire logic i_reset,
	rnd_phase_if.gen ph
);
	typedef struct packed {
		logic [1:0] phase;
	} rnd_ph_st_t;
	rnd_ph_st_t s_reg;
	rnd_ph_st_t s_next;

	always_comb begin
		s_next = s_reg;
		s_next.phase = s_reg.phase + 2'h1;
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign ph.phase = s_reg.phase;
	assign ph.last = (s_reg.phase == `RND_PHASE_LAST);
	assign ph.first = (s_reg.phase == 2'h0);
endmodule
`default_nettype wire

//--- hdl/rnd_decode.sv
// Decode and execute for no-op, interrupt return, option load and
// literal return. Assumes the fetch path presents i_instr for a whole
// instruction cycle with i_instr_valid, and the stack supplies i_stack_top.
//
// How it works
// - The no-op pattern with two free bits takes one cycle and changes nothing.
// - Interrupt return pops the stack top into the PC, sets interrupt enable bit 7, takes two cycles.
// - Option load copies W into the option register in one cycle, no flags.
// - Literal return writes the literal to W and pops the stack in the last phase, then idles a cycle.
`timescale 1ns/100ps
`default_nettype none
`include "rnd_defs.svh"
module rnd_decode (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [13:0] i_instr,
	input wire logic i_instr_valid,
	input wire logic [12:0] i_stack_top,
	input wire logic [7:0] i_w,
	input wire logic [7:0] i_interrupt_control_register,
	output logic [1:0] o_phase,
	output logic o_stack_pop,
	output logic o_pc_load,
	output logic [12:0] o_pc_value,
	output logic o_w_write,
	output logic [7:0] o_w_value,
	output logic o_option_write,
	output logic [7:0] o_option_value,
	output logic o_interrupt_control_register_write,
	output logic [7:0] o_interrupt_control_register_value,
	output logic o_flush,
	output logic o_busy
);
	import rnd_pkg::*;

	// =============================================================
	// Phase timing
	rnd_phase_if ph ();
	rnd_phase_gen u_phase (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.ph(ph)
	);

	// =============================================================
	// State
	typedef struct packed {
		rnd_state_t state;
		logic [1:0] phase;
		logic pop;
		logic pc_load;
		logic [12:0] pc;
		logic w_wr;
		logic [7:0] w;
		logic opt_wr;
		logic [7:0] opt;
		logic ic_wr;
		logic [7:0] ic;
		logic flush;
		logic busy;
	} rnd_st_t;
	rnd_st_t s_reg;
	rnd_st_t s_next;

	logic is_nop;
	logic is_retfi;
	logic is_optld;
	logic is_retlit;
	assign is_nop = (i_instr & `RND_NOP_MASK) == `RND_NOP_VAL;
	assign is_retfi = i_instr == `RND_RETFI_VAL;
	assign is_optld = i_instr == `RND_OPTLD_VAL;
	assign is_retlit = (i_instr & `RND_RETLIT_MASK) == `RND_RETLIT_VAL;

	always_comb begin
		s_next = s_reg;
		s_next.phase = ph.phase;
		// Strobes live one phase only
		s_next.pop = 1'b0;
		s_next.pc_load = 1'b0;
		s_next.w_wr = 1'b0;
		s_next.opt_wr = 1'b0;
		s_next.ic_wr = 1'b0;
		s_next.flush = 1'b0;
		case (s_reg.state)
			RND_EXEC: begin
				// No-op falls through: no strobe in any phase
				if (i_instr_valid && !is_nop) begin
					if (is_retfi && ph.phase == `RND_PHASE_GIE) begin
						s_next.ic_wr = 1'b1;
						// Read-modify-write keeps the other enable bits
						s_next.ic = i_interrupt_control_register;
						s_next.ic[`RND_GIE_BIT] = 1'b1;
					end
					if (ph.last) begin
						if (is_retfi || is_retlit) begin
							s_next.pop = 1'b1;
							s_next.pc_load = 1'b1;
							s_next.pc = i_stack_top;
							s_next.flush = 1'b1;
							s_next.busy = 1'b1;
							s_next.state = RND_IDLE;
						end
						if (is_retlit) begin
							s_next.w_wr = 1'b1;
							s_next.w = i_instr[7:0];
						end
						if (is_optld) begin
							// Kept for old code; direct writes are preferred
							s_next.opt_wr = 1'b1;
							s_next.opt = i_w;
						end
					end
				end
			end
			RND_IDLE: begin
				// Second cycle executes nothing
				if (ph.last) begin
					s_next.busy = 1'b0;
					s_next.state = RND_EXEC;
				end
			end
			default: begin
				s_next.state = RND_EXEC;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_phase = s_reg.phase;
	assign o_stack_pop = s_reg.pop;
	assign o_pc_load = s_reg.pc_load;
	assign o_pc_value = s_reg.pc;
	assign o_w_write = s_reg.w_wr;
	assign o_w_value = s_reg.w;
	assign o_option_write = s_reg.opt_wr;
	assign o_option_value = s_reg.opt;
	assign o_interrupt_control_register_write = s_reg.ic_wr;
	assign o_interrupt_control_register_value = s_reg.ic;
	assign o_flush = s_reg.flush;
	assign o_busy = s_reg.busy;
endmodule
`default_nettype wire

//--- verif/rnd_decode_properties.sv
// Checker of the decoder output strobes.
// Assumes it is bound to rnd_decode.
`timescale 1ns/100ps
`default_nettype none
module rnd_decode_props (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [1:0] o_phase,
	input wire logic o_stack_pop,
	input wire logic o_pc_load,
	input wire logic o_w_write,
	input wire logic o_option_write,
	input wire logic o_interrupt_control_register_write,
	input wire logic [7:0] o_interrupt_control_register_value,
	input wire logic o_flush,
	input wire logic o_busy
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// ==========================================
	// Return and option-load sequencing
	sequence s_idle;
		o_busy [*4] ##1 !o_busy;
	endsequence
	a_pop_with_load: assert property (o_stack_pop |->
		o_pc_load && o_flush && o_phase == 2'h3) else $error("lone pop");
	a_enable_then_pop: assert property (o_interrupt_control_register_write |->
		o_interrupt_control_register_value[7] ##1 o_stack_pop) else $error("enable order");
	a_idle_cycle: assert property (o_stack_pop |-> s_idle)
		else $error("idle cycle length");
	a_literal_pops: assert property (o_w_write |->
		o_stack_pop && !$past(o_busy)) else $error("w write alone");
	a_option_single: assert property (o_option_write |->
		!o_busy && !o_stack_pop) else $error("option not single");
	a_flush_on_pop: assert property (o_flush |->
		o_stack_pop && o_busy) else $error("flush without pop");
endmodule
bind rnd_decode rnd_decode_props u_props (.i_clk, .i_reset, .o_phase,
	.o_stack_pop, .o_pc_load, .o_w_write, .o_option_write,
	.o_interrupt_control_register_write, .o_interrupt_control_register_value, .o_flush, .o_busy);
`default_nettype wire

//--- verif/tb_return_nop_option_decode.sv
// Self-checking bench of rnd_decode.
// Assumes the design files are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_return_nop_option_decode;
	logic i_clk, i_reset, i_instr_valid;
	logic [13:0] i_instr;
	logic [12:0] i_stack_top, o_pc_value, pc_seen;
	logic [7:0] i_w, i_interrupt_control_register, o_w_value, o_option_value, o_interrupt_control_register_value;
	logic [7:0] w_seen, opt_seen, ic_seen, r;
	logic [1:0] o_phase;
	logic o_stack_pop, o_pc_load, o_w_write, o_option_write;
	logic o_interrupt_control_register_write, o_flush, o_busy;
	logic [5:0] st;
	int mismatches, samples_checked;
	logic [13:0] corner [9] = '{14'h0000, 14'h0020, 14'h0040, 14'h0060,
		14'h0009, 14'h0062, 14'h3400, 14'h35ff, 14'h37a5};
	rnd_decode dut (.i_clk, .i_reset, .i_instr, .i_instr_valid,
		.i_stack_top, .i_w, .i_interrupt_control_register, .o_phase, .o_stack_pop, .o_pc_load,
		.o_pc_value, .o_w_write, .o_w_value, .o_option_write,
		.o_option_value, .o_interrupt_control_register_write, .o_interrupt_control_register_value, .o_flush,
		.o_busy);
	// ==========================================
	// Helpers
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	// Strobes: pop, pc load, w, option, enable, flush
	function automatic logic [5:0] exp_st(input logic [13:0] c);
		if (c == 14'h0009) return 6'h33;
		if (c[13:10] == 4'hd) return 6'h39;
		if (c == 14'h0062) return 6'h04;
		return 6'h00;
	endfunction
	task automatic check(input logic [12:0] seen, input logic [12:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	always @(negedge i_clk) begin
		st |= {o_stack_pop, o_pc_load, o_w_write, o_option_write,
			o_interrupt_control_register_write, o_flush};
		if (o_pc_load) pc_seen = o_pc_value;
		if (o_w_write) w_seen = o_w_value;
		if (o_option_write) opt_seen = o_option_value;
		if (o_interrupt_control_register_write) ic_seen = o_interrupt_control_register_value;
	end
	// Option load offered during the idle cycle must be ignored
	task automatic op(input logic [13:0] c, input logic v);
		logic [5:0] e;
		e = v ? exp_st(c) : 6'h00;
		r = lfsr(r);
		i_w = r;
		r = lfsr(r);
		i_interrupt_control_register = r & 8'h7f;
		i_stack_top = {r[4:0], i_w};
		i_instr = c;
		i_instr_valid = v;
		@(posedge i_clk) st = 6'h00;
		repeat (4) @(negedge i_clk);
		i_instr = 14'h0062;
		i_instr_valid = e[5];
		repeat (4) @(negedge i_clk);
		check(st, e);
		if (e[4]) check(pc_seen, i_stack_top);
		if (e[3]) check(w_seen, c[7:0]);
		if (e[2]) check(opt_seen, i_w);
		if (e[1]) check(ic_seen, i_interrupt_control_register | 8'h80);
		check(o_busy, 1'b0);
		check(o_phase, 2'h3);
		$display("test done %h", c);
	endtask
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	initial begin
		#5000;
		mismatches++;
		give_verdict();
	end
	initial begin
		i_reset = 1'b1;
		i_instr = 14'h0000;
		i_instr_valid = 1'b0;
		i_w = 8'h00;
		i_interrupt_control_register = 8'h00;
		i_stack_top = 13'h0000;
		st = 6'h00;
		r = 8'h60;
		repeat (8) @(negedge i_clk);
		i_reset = 1'b0;
		foreach (corner[i]) op(corner[i], 1'b1);
		op(14'h0009, 1'b0);
		repeat (20) begin
			r = lfsr(r);
			op({r[5:0], lfsr(r)}, 1'b1);
		end
		give_verdict();
	end
endmodule
`default_nettype wire
